// ===== verilog/serial_cfg_device.sv
// Purpose: Device end of the serial configuration port.
// Assumes: Link logic runs on the host's serial clock only.
// Notes: Completed writes are handed to clk_sys by a toggle.
`timescale 1ns/1ps
module serial_cfg_device
   import serial_cfg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   serial_cfg_if.device link,
   output logic cfg_write,
   output logic [6:0] cfg_addr,
   output logic [15:0] cfg_data,
   output logic four_wire_select
);
   logic link_rst;
   logic [4:0] cnt, next_cnt;
   logic [6:0] instr, next_instr;
   logic [6:0] addr, next_addr;
   logic is_read, next_is_read;
   logic [14:0] din, next_din;
   logic [15:0] rd_word, next_rd_word;
   logic [15:0] setup_reg, next_setup_reg;
   logic [15:0] mem [0:(1 << ADDR_BITS) - 1];
   logic wr_now;
   logic [15:0] wr_word;
   logic wr_tog, next_wr_tog;
   logic [6:0] wr_addr_l, next_wr_addr_l;
   logic [15:0] wr_data_l, next_wr_data_l;
   logic four;
   logic [4:0] idx;
   logic drive, final_bit, out_bit;
   logic dio_o, next_dio_o;
   logic dio_oe_n, next_dio_oe_n;
   logic out_o, next_out_o;
   logic out_oe_n, next_out_oe_n;
   logic tog_s1, tog_s2, tog_s3;
   logic four_s1, four_s2;
   logic next_cfg_write;
   logic [6:0] next_cfg_addr;
   logic [15:0] next_cfg_data;

   // A high enable clears all frame state without a clock edge
   assign link_rst = link.serial_enable_n | sys_rst;
   assign four = setup_reg[FOUR_WIRE_POS];

   // ==========================================================
   // Rising edge: bit counter, instruction and write capture
   always_comb
   begin
      next_cnt = cnt;
      next_instr = instr;
      next_addr = addr;
      next_is_read = is_read;
      next_din = din;
      next_rd_word = rd_word;
      if (cnt != CNT_FRAME_END)
      begin
         next_cnt = cnt + 5'h01;
      end
      if (cnt < CNT_INSTR_LAST)
      begin
         next_instr = {instr[5:0], link.dio_line};
      end
      if (cnt == CNT_INSTR_LAST)
      begin
         next_is_read = instr[6];
         next_addr = {instr[5:0], link.dio_line};
         if ({instr[5:0], link.dio_line} == SETUP_ADDR)
         begin
            next_rd_word = setup_reg;
         end
         else
         begin
            next_rd_word = mem[{instr[5:0], link.dio_line}];
         end
      end
      if (cnt >= CNT_DATA_FIRST && cnt < CNT_DATA_LAST)
      begin
         next_din = {din[13:0], link.dio_line};
      end
   end

   always_ff @(posedge link.serial_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         cnt <= 5'h00;
         instr <= 7'h00;
         addr <= 7'h00;
         is_read <= 1'b0;
         din <= 15'h0000;
         rd_word <= 16'h0000;
      end
      else
      begin
         cnt <= next_cnt;
         instr <= next_instr;
         addr <= next_addr;
         is_read <= next_is_read;
         din <= next_din;
         rd_word <= next_rd_word;
      end
   end

   // ==========================================================
   // Register storage, survives between frames
   assign wr_now = (cnt == CNT_DATA_LAST) && !is_read;
   assign wr_word = {din, link.dio_line};

   always_comb
   begin
      next_setup_reg = setup_reg;
      next_wr_tog = wr_tog;
      next_wr_addr_l = wr_addr_l;
      next_wr_data_l = wr_data_l;
      if (wr_now)
      begin
         next_wr_tog = !wr_tog;
         next_wr_addr_l = addr;
         next_wr_data_l = wr_word;
         if (addr == SETUP_ADDR)
         begin
            next_setup_reg = wr_word;
         end
      end
   end

   always_ff @(posedge link.serial_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         setup_reg <= SETUP_RESET;
         wr_tog <= 1'b0;
         wr_addr_l <= 7'h00;
         wr_data_l <= 16'h0000;
      end
      else
      begin
         setup_reg <= next_setup_reg;
         wr_tog <= next_wr_tog;
         wr_addr_l <= next_wr_addr_l;
         wr_data_l <= next_wr_data_l;
      end
   end

   always_ff @(posedge link.serial_clk)
   begin
      if (wr_now)
      begin
         mem[addr] <= wr_word;
      end
   end

   // ==========================================================
   // Falling edge: read data and pin enables
   assign idx = 5'(FRAME_BITS - 1) - cnt;
   assign drive = is_read && (cnt >= CNT_DATA_FIRST);
   assign final_bit = cnt == CNT_FRAME_END;
   assign out_bit = final_bit ? 1'b0 : rd_word[idx[3:0]];

   always_comb
   begin
      next_dio_o = 1'b0;
      next_out_o = 1'b0;
      next_dio_oe_n = 1'b1;
      next_out_oe_n = 1'b1;
      if (drive)
      begin
         next_dio_o = out_bit;
         next_out_o = out_bit;
         if (!four || final_bit)
         begin
            next_dio_oe_n = 1'b0;
         end
         if (four || final_bit)
         begin
            next_out_oe_n = 1'b0;
         end
      end
   end

   always_ff @(negedge link.serial_clk or posedge link_rst)
   begin
      if (link_rst)
      begin
         dio_o <= 1'b0;
         dio_oe_n <= 1'b1;
         out_o <= 1'b0;
         out_oe_n <= 1'b1;
      end
      else
      begin
         dio_o <= next_dio_o;
         dio_oe_n <= next_dio_oe_n;
         out_o <= next_out_o;
         out_oe_n <= next_out_oe_n;
      end
   end

   assign link.dio_dev_o = dio_o;
   assign link.dio_dev_oe_n = dio_oe_n;
   assign link.serial_data_out = out_o;
   assign link.serial_data_out_oe_n = out_oe_n;

   // ==========================================================
   // clk_sys side: write notification and mode level
   always_comb
   begin
      next_cfg_write = tog_s2 ^ tog_s3;
      next_cfg_addr = cfg_addr;
      next_cfg_data = cfg_data;
      if (tog_s2 ^ tog_s3)
      begin
         next_cfg_addr = wr_addr_l;
         next_cfg_data = wr_data_l;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
         four_s1 <= 1'b0;
         four_s2 <= 1'b0;
         cfg_write <= 1'b0;
         cfg_addr <= 7'h00;
         cfg_data <= 16'h0000;
         four_wire_select <= 1'b0;
      end
      else
      begin
         tog_s1 <= wr_tog;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
         four_s1 <= four;
         four_s2 <= four_s1;
         cfg_write <= next_cfg_write;
         cfg_addr <= next_cfg_addr;
         cfg_data <= next_cfg_data;
         four_wire_select <= four_s2;
      end
   end
endmodule

// ===== verilog/serial_cfg_pkg.sv
// Purpose: Shared constants and types for the serial configuration port.
// Assumes: Frame = instruction byte plus one 16-bit data word.
// Notes: Host and device ends both import this package.
package serial_cfg_pkg;
   // ==========================================================
   // Frame layout
   localparam int INSTR_BITS = 8;
   localparam int DATA_BITS = 16;
   localparam int FRAME_BITS = 24;
   localparam int ADDR_BITS = 7;
   localparam logic [4:0] CNT_INSTR_LAST = 5'h07;
   localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
   localparam logic [4:0] CNT_DATA_LAST = 5'h17;
   localparam logic [4:0] CNT_FRAME_END = 5'h18;
   // ==========================================================
   // Setup register
   localparam logic [6:0] SETUP_ADDR = 7'h02;
   localparam logic [15:0] SETUP_RESET = 16'h7000;
   localparam int FOUR_WIRE_POS = 7;
   // ==========================================================
   // Host serial clock divider: half period in clk_sys cycles, at least 3
   localparam logic [2:0] SCLK_HALF = 3'h4;
   typedef enum logic [1:0]
   {
      H_IDLE = 2'h0,
      H_LEAD = 2'h1,
      H_SHIFT = 2'h3,
      H_TAIL = 2'h2
   } host_state_type;
endpackage

// ===== verilog/serial_cfg_if.sv
// Purpose: Pins of the serial configuration link between host and device.
// Assumes: Undriven lines float high through a pull-up.
// Notes: Resolves the shared data pin from both output enables.
`timescale 1ns/1ps
interface serial_cfg_if;
   logic serial_clk;
   logic serial_enable_n;
   logic dio_host_o;
   logic dio_host_oe_n;
   logic dio_dev_o;
   logic dio_dev_oe_n;
   logic serial_data_out;
   logic serial_data_out_oe_n;
   logic dio_line;
   logic out_line;
   // ==========================================================
   // Wire resolution
   assign dio_line = !dio_host_oe_n ? dio_host_o : (!dio_dev_oe_n ? dio_dev_o : 1'b1);
   assign out_line = !serial_data_out_oe_n ? serial_data_out : 1'b1;
   modport device
   (
      input serial_clk,
      input serial_enable_n,
      input dio_line,
      output dio_dev_o,
      output dio_dev_oe_n,
      output serial_data_out,
      output serial_data_out_oe_n
   );
   modport host
   (
      output serial_clk,
      output serial_enable_n,
      output dio_host_o,
      output dio_host_oe_n,
      input dio_line,
      input out_line
   );
endinterface

// ===== verilog/serial_cfg_host.sv
// Purpose: Host end; runs one register read or write per request.
// Assumes: Serial clock derived from clk_sys by the divider.
// Notes: Returned bits pass two flip-flops before sampling.
`timescale 1ns/1ps
module serial_cfg_host
   import serial_cfg_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   serial_cfg_if.host link,
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic [6:0] req_addr,
   input wire logic [15:0] req_data,
   input wire logic four_wire_mode,
   output logic busy,
   output logic done,
   output logic [15:0] rd_data
);
   host_state_type state, next_state;
   logic [2:0] div, next_div;
   logic [4:0] bits, next_bits;
   logic [23:0] shreg, next_shreg;
   logic [15:0] rd_shift, next_rd_shift, next_rd_data;
   logic is_read, next_is_read;
   logic sclk, next_sclk;
   logic enable_n, next_enable_n;
   logic dio_o, next_dio_o;
   logic dio_oe_n, next_dio_oe_n;
   logic next_busy, next_done;
   logic dio_s1, dio_s2, out_s1, out_s2;

   // ==========================================================
   // Frame sequencer
   always_comb
   begin
      next_state = state;
      next_div = div;
      next_bits = bits;
      next_shreg = shreg;
      next_rd_shift = rd_shift;
      next_rd_data = rd_data;
      next_is_read = is_read;
      next_sclk = sclk;
      next_enable_n = enable_n;
      next_dio_o = dio_o;
      next_dio_oe_n = dio_oe_n;
      next_busy = busy;
      next_done = 1'b0;
      case (state)
         H_IDLE:
         begin
            if (req_valid)
            begin
               next_state = H_LEAD;
               next_enable_n = 1'b0;
               next_shreg = {req_read, req_addr, req_data};
               next_dio_o = req_read;
               next_dio_oe_n = 1'b0;
               next_is_read = req_read;
               next_busy = 1'b1;
               next_div = 3'h0;
               next_bits = 5'h00;
            end
         end
         H_LEAD:
         begin
            next_div = div + 3'h1;
            if (div == SCLK_HALF - 3'h1)
            begin
               next_div = 3'h0;
               next_sclk = 1'b1;
               next_bits = 5'h01;
               next_state = H_SHIFT;
            end
         end
         H_SHIFT:
         begin
            next_div = div + 3'h1;
            if (div == SCLK_HALF - 3'h1)
            begin
               next_div = 3'h0;
               next_sclk = !sclk;
               if (sclk)
               begin
                  // Falling edge: present the next bit for the device's rising edge
                  if (bits == CNT_FRAME_END)
                  begin
                     next_state = H_TAIL;
                     next_dio_oe_n = 1'b1;
                  end
                  else
                  begin
                     next_shreg = {shreg[22:0], 1'b0};
                     next_dio_o = shreg[22];
                     if (is_read && bits >= CNT_DATA_FIRST)
                     begin
                        next_dio_oe_n = 1'b1;
                     end
                  end
               end
               else
               begin
                  next_bits = bits + 5'h01;
                  if (is_read && bits >= CNT_DATA_FIRST)
                  begin
                     next_rd_shift = {rd_shift[14:0], four_wire_mode ? out_s2 : dio_s2};
                  end
               end
            end
         end
         H_TAIL:
         begin
            next_div = div + 3'h1;
            if (div == SCLK_HALF - 3'h1)
            begin
               next_div = 3'h0;
               next_enable_n = 1'b1;
               next_busy = 1'b0;
               next_done = 1'b1;
               if (is_read)
               begin
                  next_rd_data = rd_shift;
               end
               next_state = H_IDLE;
            end
         end
         default:
         begin
            next_state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= H_IDLE;
         div <= 3'h0;
         bits <= 5'h00;
         shreg <= 24'h00_0000;
         rd_shift <= 16'h0000;
         rd_data <= 16'h0000;
         is_read <= 1'b0;
         sclk <= 1'b0;
         enable_n <= 1'b1;
         dio_o <= 1'b0;
         dio_oe_n <= 1'b1;
         busy <= 1'b0;
         done <= 1'b0;
         dio_s1 <= 1'b1;
         dio_s2 <= 1'b1;
         out_s1 <= 1'b1;
         out_s2 <= 1'b1;
      end
      else
      begin
         state <= next_state;
         div <= next_div;
         bits <= next_bits;
         shreg <= next_shreg;
         rd_shift <= next_rd_shift;
         rd_data <= next_rd_data;
         is_read <= next_is_read;
         sclk <= next_sclk;
         enable_n <= next_enable_n;
         dio_o <= next_dio_o;
         dio_oe_n <= next_dio_oe_n;
         busy <= next_busy;
         done <= next_done;
         dio_s1 <= link.dio_line;
         dio_s2 <= dio_s1;
         out_s1 <= link.out_line;
         out_s2 <= out_s1;
      end
   end

   assign link.serial_clk = sclk;
   assign link.serial_enable_n = enable_n;
   assign link.dio_host_o = dio_o;
   assign link.dio_host_oe_n = dio_oe_n;
endmodule

// ===== dv/dac_serial_config_port_chk.sv
// Purpose: Timing checks on the serial configuration link pins.
// Assumes: All link signals are flops of clk_sys or settle within one cycle.
// Notes: Frame position is tracked by counting serial clock rises.
`timescale 1ns/1ps
module dac_serial_config_port_chk
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic serial_enable_n,
   input wire logic dio_host_oe_n,
   input wire logic dio_dev_o,
   input wire logic dio_dev_oe_n,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe_n,
   input wire logic dio_line
);
   logic sclk_q;
   logic [4:0] rises;
   logic rd_flag;
   logic next_sclk_q;
   logic [4:0] next_rises;
   logic next_rd_flag;
   // ==========================================================
   // Frame tracker
   always_comb
   begin
      next_sclk_q = serial_clk;
      next_rises = rises;
      next_rd_flag = rd_flag;
      if (serial_enable_n)
      begin
         next_rises = 5'h00;
      end
      else if (serial_clk && !sclk_q && rises != 5'h1f)
      begin
         next_rises = rises + 5'h01;
         if (rises == 5'h00)
         begin
            next_rd_flag = dio_line;
         end
      end
   end
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclk_q <= 1'b0;
         rises <= 5'h00;
         rd_flag <= 1'b0;
      end
      else
      begin
         sclk_q <= next_sclk_q;
         rises <= next_rises;
         rd_flag <= next_rd_flag;
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_idle_release;
      serial_enable_n |-> dio_dev_oe_n && serial_data_out_oe_n;
   endproperty
   property p_one_pin;
      !(rises == 5'h18 && !serial_clk) |-> !(!dio_dev_oe_n && !serial_data_out_oe_n);
   endproperty
   property p_no_early;
      (!dio_dev_oe_n || !serial_data_out_oe_n) |-> rises >= 5'h08;
   endproperty
   property p_write_quiet;
      (!rd_flag && rises != 5'h00) |-> dio_dev_oe_n && serial_data_out_oe_n;
   endproperty
   property p_read_drive;
      (rd_flag && rises >= 5'h09 && !serial_enable_n && !(rises == 5'h18 && !serial_clk))
         |-> dio_dev_oe_n != serial_data_out_oe_n;
   endproperty
   property p_dio_falling;
      (serial_clk && $past(serial_clk) && !dio_dev_oe_n && $past(dio_dev_oe_n) == 1'b0)
         |-> $stable(dio_dev_o);
   endproperty
   property p_out_falling;
      (serial_clk && $past(serial_clk) && !serial_data_out_oe_n
         && $past(serial_data_out_oe_n) == 1'b0) |-> $stable(serial_data_out);
   endproperty
   property p_tail_low;
      (rd_flag && rises == 5'h18 && !serial_clk && !serial_enable_n)
         |-> (!dio_dev_oe_n && !dio_dev_o) && (!serial_data_out_oe_n && !serial_data_out);
   endproperty
   property p_frame_len;
      $rose(serial_enable_n) |-> rises == 5'h18;
   endproperty
   property p_host_instr;
      (!serial_enable_n && rises < 5'h08) |-> !dio_host_oe_n;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("device drives a pin outside a frame");
   a_one_pin: assert property (p_one_pin)
      else $error("device drives both data pins");
   a_no_early: assert property (p_no_early)
      else $error("device drives before instruction is complete");
   a_write_quiet: assert property (p_write_quiet)
      else $error("device drives during a write frame");
   a_read_drive: assert property (p_read_drive)
      else $error("read data phase without exactly one driven pin");
   a_dio_falling: assert property (p_dio_falling)
      else $error("data pin changed while serial clock high");
   a_out_falling: assert property (p_out_falling)
      else $error("output pin changed while serial clock high");
   a_tail_low: assert property (p_tail_low)
      else $error("pin not low after last falling edge");
   a_frame_len: assert property (p_frame_len)
      else $error("frame closed without 24 clock rises");
   a_host_instr: assert property (p_host_instr)
      else $error("host not driving instruction bits");
   c_write: cover property ($rose(serial_enable_n) && !rd_flag);
   c_read3: cover property (rd_flag && rises == 5'h10 && !dio_dev_oe_n);
   c_read4: cover property (rd_flag && rises == 5'h10 && !serial_data_out_oe_n);
endmodule

// ===== dv/dac_serial_config_port_tb.sv
// Purpose: Host and device ends joined; random register traffic in both modes.
// Assumes: Written addresses are read back before anything overwrites them.
// Notes: Instruction bits, write data and three-wire read data are also captured straight off the wire.
`timescale 1ns/1ps
module dac_serial_config_port_tb;
   import serial_cfg_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b0;
   logic req_valid = 1'b0;
   logic req_read = 1'b0;
   logic [6:0] req_addr = 7'h00;
   logic [15:0] req_data = 16'h0000;
   logic four_wire_mode = 1'b0;
   logic busy, done, cfg_write, four_wire_select, wr_seen;
   logic [15:0] rd_data, cfg_data, wr_d, v;
   logic [6:0] cfg_addr, wr_a, a;
   logic [23:0] wire_bits;
   logic [31:0] seed = 32'h0000_2758;
   int n_errors = 0;
   int num_checks = 0;
   serial_cfg_if u_serial_cfg_if();
   serial_cfg_host u_serial_cfg_host(.clk_sys(clk_sys), .sys_rst(sys_rst),
      .link(u_serial_cfg_if), .req_valid(req_valid), .req_read(req_read),
      .req_addr(req_addr), .req_data(req_data), .four_wire_mode(four_wire_mode),
      .busy(busy), .done(done), .rd_data(rd_data));
   serial_cfg_device u_serial_cfg_device(.clk_sys(clk_sys), .sys_rst(sys_rst),
      .link(u_serial_cfg_if), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
      .cfg_data(cfg_data), .four_wire_select(four_wire_select));
   dac_serial_config_port_chk u_dac_serial_config_port_chk(.clk_sys(clk_sys),
      .sys_rst(sys_rst), .serial_clk(u_serial_cfg_if.serial_clk),
      .serial_enable_n(u_serial_cfg_if.serial_enable_n),
      .dio_host_oe_n(u_serial_cfg_if.dio_host_oe_n), .dio_dev_o(u_serial_cfg_if.dio_dev_o),
      .dio_dev_oe_n(u_serial_cfg_if.dio_dev_oe_n),
      .serial_data_out(u_serial_cfg_if.serial_data_out),
      .serial_data_out_oe_n(u_serial_cfg_if.serial_data_out_oe_n),
      .dio_line(u_serial_cfg_if.dio_line));
   always #12.5 clk_sys = ~clk_sys;
   // ==========================================================
   // Monitors
   always @(posedge clk_sys)
   begin
      if (cfg_write === 1'b1)
      begin
         wr_seen <= 1'b1;
         wr_a <= cfg_addr;
         wr_d <= cfg_data;
      end
   end
   // Each frame is 24 rises, so older frames shift out
   always @(posedge u_serial_cfg_if.serial_clk)
   begin
      if (!u_serial_cfg_if.serial_enable_n)
      begin
         wire_bits <= {wire_bits[22:0], u_serial_cfg_if.dio_line};
      end
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic logic [23:0] frame_of(input logic rd, input logic [6:0] ad,
                                            input logic [15:0] d);
      return {rd, ad, d};
   endfunction
   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic mismatch(input string msg);
      n_errors++;
      $display("ERROR %0t: %s", $time, msg);
   endtask
   task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp)
         mismatch($sformatf("word %h expected %h", got, exp));
   endtask
   task automatic check_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
         mismatch($sformatf("bit %b expected %b", got, exp));
   endtask
   task automatic xfer(input logic rd, input logic [6:0] ad, input logic [15:0] d);
      int i;
      @(posedge clk_sys);
      #1;
      req_valid = 1'b1;
      req_read = rd;
      req_addr = ad;
      req_data = d;
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      check_bit(busy, 1'b1);
      for (i = 0; i < 400; i++)
      begin
         @(posedge clk_sys);
         #1;
         if (done === 1'b1)
            break;
      end
      if (i == 400)
      begin
         mismatch("no done");
         results();
      end
      check_bit(busy, 1'b0);
   endtask
   task automatic wr(input logic [6:0] ad, input logic [15:0] d);
      int i;
      wr_seen = 1'b0;
      xfer(1'b0, ad, d);
      for (i = 0; i < 20 && wr_seen !== 1'b1; i++)
         @(posedge clk_sys);
      check_bit(wr_seen, 1'b1);
      check_word({17'h0_0000, wr_a}, {17'h0_0000, ad});
      check_word({8'h00, wr_d}, {8'h00, d});
      check_word(wire_bits, frame_of(1'b0, ad, d));
   endtask
   task automatic rd(input logic [6:0] ad, input logic [15:0] e);
      xfer(1'b1, ad, 16'h0000);
      check_word({8'h00, rd_data}, {8'h00, e});
      check_word({16'h0000, wire_bits[23:16]}, {16'h0000, 1'b1, ad});
      if (!four_wire_mode)
         check_word({8'h00, wire_bits[15:0]}, {8'h00, e});
   endtask
   task automatic set_mode(input logic m);
      int i;
      seed = xs(seed);
      v = seed[15:0];
      v[FOUR_WIRE_POS] = m;
      wr(SETUP_ADDR, v);
      for (i = 0; i < 10 && four_wire_select !== m; i++)
         @(posedge clk_sys);
      check_bit(four_wire_select, m);
      four_wire_mode = m;
      rd(SETUP_ADDR, v);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      // Rising reset edge so every asynchronous reset branch is taken
      #1;
      sys_rst = 1'b1;
      repeat (16) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
      check_bit(four_wire_select, 1'b0);
      rd(SETUP_ADDR, SETUP_RESET);
      $display("test reset_defaults done");
      for (int m = 0; m < 2; m++)
      begin
         set_mode(m[0]);
         wr(7'h7f, 16'hffff);
         for (int k = 0; k < 6; k++)
         begin
            seed = xs(seed);
            a = seed[22:16];
            if (a == SETUP_ADDR || a == 7'h7f)
               a = a ^ 7'h01;
            wr(a, seed[15:0]);
            rd(a, seed[15:0]);
         end
         rd(7'h7f, 16'hffff);
         wr(7'h7f, 16'h0000);
         rd(7'h7f, 16'h0000);
         $display("test mode %0d traffic done", m);
      end
      set_mode(1'b0);
      $display("test return_three_wire done");
      results();
   end
endmodule
